// File: src/cms_pkg.sv
// Package with the register map, field layout and carrier types of the core mode register file.
package cms_pkg;

  // ----------------------------------------------------------------------
  // Widths and register indices
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int GPR_N = 16;
  localparam int IDX_W = 4;
  localparam int PRIO_W = 9;
  localparam int EXCNUM_W = 9;
  localparam int FLAGS_W = 5;
  localparam int ICI_W = 6;
  localparam int IT_W = 2;
  localparam int CTRL_W = 2;
  localparam logic [IDX_W-1:0] LOW_REG_LAST = 4'h7;
  localparam logic [IDX_W-1:0] HIGH_REG_LAST = 4'hC;
  localparam logic [IDX_W-1:0] SP_IDX = 4'hD;
  localparam logic [IDX_W-1:0] LR_IDX = 4'hE;
  localparam logic [IDX_W-1:0] PC_IDX = 4'hF;

  // ----------------------------------------------------------------------
  // Bus byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GPR_LAST = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_MSP = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PSP = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_COMBINED_PROGRAM_STATUS = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_IRQ_BLOCK = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_FAULT_LEVEL_BLOCK = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY_THRESHOLD = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h5C;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int FLAGS_LSB = 27;
  localparam int ICI_LSB = 10;
  localparam int IT_LSB = 25;
  localparam int EXEC_BIT = 24;
  localparam int CTRL_PRIV_BIT = 0;
  localparam int CTRL_STACK_BIT = 1;
  localparam int MODE_HANDLER_BIT = 1;
  localparam int STATE_HANDLER_BIT = 0;
  localparam int STATE_PRIV_BIT = 1;
  localparam int STATE_PSP_BIT = 2;
  localparam int STATE_EXC_LSB = 16;
  localparam logic [DATA_W-1:0] SP_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [DATA_W-1:0] PC_ALIGN_MASK = 32'hFFFF_FFFE;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] PRIORITY_THRESHOLD_OFF = 9'h000;
  localparam logic [EXCNUM_W-1:0] EXCNUM_NONE = 9'h000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CMS_THREAD = 2'b01, CMS_HANDLER = 2'b10} cms_mode_e;
  typedef enum logic [1:0] {CMS_EXC_NMI = 2'h0, CMS_EXC_HARD = 2'h1, CMS_EXC_OTHER = 2'h2}
    cms_exc_kind_e;

  typedef struct packed {
    logic callValid;
    logic [DATA_W-1:0] retAddr;
    logic excEnter;
    logic [EXCNUM_W-1:0] excNum;
    logic excReturn;
    logic gprWrValid;
    logic gprNarrow;
    logic [IDX_W-1:0] gprIdx;
    logic [DATA_W-1:0] gprData;
    logic flagsValid;
    logic [FLAGS_W-1:0] flags;
  } cms_core_evt_s;

  typedef struct packed {
    logic valid;
    cms_exc_kind_e kind;
    logic [PRIO_W-1:0] prio;
  } cms_irq_req_s;

endpackage

// File: src/cms_cpu_mode_regs.sv
// Core register file with banked stack pointer, status views, masks and mode control.
`timescale 1ns/10ps

// Overview of operation
// (RULE_01) Only privileged handler, privileged thread and unprivileged thread states exist.
// (RULE_02) Unprivileged access to special registers is blocked and raises a fault.
// (RULE_03) Exception service runs in privileged handler mode, otherwise thread mode.
// (RULE_04) All sixteen core registers are 32 bits wide.
// (RULE_05) Narrow instructions reach only registers 0 to 7; wide ones reach 0 to 12.
// (RULE_06) Stack pointer is banked; process copy only in thread mode, main otherwise.
// (RULE_07) Stack pointer low two bits are forced to zero.
// (RULE_08) A subroutine call writes its return address into the return link.
// (RULE_09) Instruction pointer bit zero is forced to zero.
// (RULE_10) Application flags occupy the top five status bits.
// (RULE_11) Current exception number occupies the nine low status bits.
// (RULE_12) Continuable and if-then state occupy two separate status ranges.
// (RULE_13) Status bit 24 reads one; an attempt to clear it faults.
// (RULE_14) Global block passes only non-maskable interrupt and hard fault.
// (RULE_15) Fault block passes only the non-maskable interrupt.
// (RULE_16) Threshold blocks priorities at or above it; zero disables it.
// (RULE_17) Mode bit 0 selects privileged or unprivileged thread level.
// (RULE_18) Mode bit 1 selects main or process stack; handler mode has none.
// (RULE_19) External reset pin is active low and idles inactive.
// (RULE_20) Reset gives privileged thread, main stack, masks and mode cleared.
module cms_cpu_mode_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic external_reset_n_pin,
  input wire logic [cms_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cms_pkg::DATA_W-1:0] avs_writedata,
  output logic [cms_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cms_pkg::cms_core_evt_s coreEvt,
  input wire cms_pkg::cms_irq_req_s irqReq,
  output logic faultEvent,
  output logic irqAccept,
  output logic handlerMode
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [cms_pkg::DATA_W-1:0] spAlign(input logic [cms_pkg::DATA_W-1:0] v);
    spAlign = v & cms_pkg::SP_ALIGN_MASK;
  endfunction

  function automatic logic maskAllows(input cms_pkg::cms_irq_req_s r, input logic priBlk,
                                      input logic fltBlk, input logic [cms_pkg::PRIO_W-1:0] thr);
    logic prioOk;
    prioOk = (thr == cms_pkg::PRIORITY_THRESHOLD_OFF) || (r.prio < thr);
    case (r.kind)
      cms_pkg::CMS_EXC_NMI: maskAllows = 1'b1;
      cms_pkg::CMS_EXC_HARD: maskAllows = !fltBlk;
      default: maskAllows = !fltBlk && !priBlk && prioOk;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic extRstMeta_q;
  logic extRstSync_q;
  logic rstInt;
  logic [cms_pkg::DATA_W-1:0] regFile_q [0:cms_pkg::GPR_N-1];
  logic [cms_pkg::DATA_W-1:0] mainSp_q;
  logic [cms_pkg::DATA_W-1:0] procSp_q;
  cms_pkg::cms_mode_e modeState_q;
  logic [cms_pkg::FLAGS_W-1:0] appFlags_q;
  logic [cms_pkg::ICI_W-1:0] iciState_q;
  logic [cms_pkg::IT_W-1:0] itState_q;
  logic [cms_pkg::EXCNUM_W-1:0] excNum_q;
  logic globalIrqBlock_q;
  logic faultLevelBlock_q;
  logic [cms_pkg::PRIO_W-1:0] priorityThreshold_q;
  logic [cms_pkg::CTRL_W-1:0] modeStackSelect_q;
  logic waitReq_q;
  logic [cms_pkg::DATA_W-1:0] readData_q;
  logic fault_q;
  logic irqAccept_q;

  // ----------------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      extRstMeta_q <= 1'b1;
      extRstSync_q <= 1'b1;
    end else begin
      extRstMeta_q <= external_reset_n_pin;
      extRstSync_q <= extRstMeta_q;
    end
  end

  assign rstInt = reset || !extRstSync_q; // RULE_19

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire inHandler = modeState_q[cms_pkg::MODE_HANDLER_BIT];
  // Handler mode ignores the level bit, so handler is always privileged.
  wire privileged = inHandler || !modeStackSelect_q[cms_pkg::CTRL_PRIV_BIT]; // RULE_01 RULE_17
  // Handler mode always runs on the main stack whatever the select bit holds.
  wire useProc = !inHandler && modeStackSelect_q[cms_pkg::CTRL_STACK_BIT]; // RULE_06 RULE_18
  wire [cms_pkg::DATA_W-1:0] curSp = useProc ? procSp_q : mainSp_q;

  wire [cms_pkg::DATA_W-1:0] statusWord = {appFlags_q, itState_q, 1'b1, 8'h00, iciState_q, 1'b0,
                                           excNum_q}; // RULE_10 RULE_11 RULE_12 RULE_13

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire busReq = avs_read || avs_write;
  wire busTake = busReq && !waitReq_q;
  wire [cms_pkg::IDX_W-1:0] busIdx = avs_address[5:2];
  wire isGpr = avs_address <= cms_pkg::OFS_GPR_LAST;
  wire isMsp = avs_address == cms_pkg::OFS_MSP;
  wire isPsp = avs_address == cms_pkg::OFS_PSP;
  wire isXpsr = avs_address == cms_pkg::OFS_COMBINED_PROGRAM_STATUS;
  wire isPri = avs_address == cms_pkg::OFS_GLOBAL_IRQ_BLOCK;
  wire isFlt = avs_address == cms_pkg::OFS_FAULT_LEVEL_BLOCK;
  wire isThr = avs_address == cms_pkg::OFS_PRIORITY_THRESHOLD;
  wire isCtrl = avs_address == cms_pkg::OFS_CONTROL;
  wire isState = avs_address == cms_pkg::OFS_STATE;
  wire isSpecial = isMsp || isPsp || isXpsr || isPri || isFlt || isThr || isCtrl;
  // The block must already hold in the request cycle, when read data is latched.
  wire privBlock = isSpecial && !privileged; // RULE_02
  wire privFault = busTake && privBlock; // RULE_02
  wire execClear = busTake && avs_write && isXpsr && privileged &&
                   !avs_writedata[cms_pkg::EXEC_BIT]; // RULE_13
  wire narrowFault = coreEvt.gprWrValid && coreEvt.gprNarrow &&
                     coreEvt.gprIdx > cms_pkg::LOW_REG_LAST &&
                     coreEvt.gprIdx <= cms_pkg::HIGH_REG_LAST; // RULE_05
  wire busWr = busTake && avs_write && !privFault;
  wire coreGprWr = coreEvt.gprWrValid && !narrowFault;

  wire [cms_pkg::DATA_W-1:0] stateWord = {7'h00, excNum_q, 13'h0000, useProc, privileged,
                                          inHandler};
  wire [cms_pkg::DATA_W-1:0] gprRead = (busIdx == cms_pkg::SP_IDX) ? curSp : regFile_q[busIdx];
  wire [cms_pkg::DATA_W-1:0] readMux =
    privBlock ? cms_pkg::ZERO_WORD : // RULE_02
    isGpr ? gprRead :
    isMsp ? mainSp_q :
    isPsp ? procSp_q :
    isXpsr ? statusWord :
    isPri ? {31'h0000_0000, globalIrqBlock_q} :
    isFlt ? {31'h0000_0000, faultLevelBlock_q} :
    isThr ? {23'h00_0000, priorityThreshold_q} :
    isCtrl ? {30'h0000_0000, modeStackSelect_q} :
    isState ? stateWord : cms_pkg::ZERO_WORD;

  // ----------------------------------------------------------------------
  // Bus handshake with one wait state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      waitReq_q <= 1'b1;
      readData_q <= cms_pkg::ZERO_WORD;
    end else if (clkEn) begin
      waitReq_q <= !(busReq && waitReq_q);
      if (busReq && waitReq_q) begin
        readData_q <= readMux;
      end
    end
  end

  // Read data is latched in the request cycle and writes and fault checks are taken in the answer cycle, so the select must stay put.
  wire [cms_pkg::DATA_W-1:0] busWd = avs_writedata;

  // ----------------------------------------------------------------------
  // General registers, link and instruction pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      for (int i = 0; i < cms_pkg::GPR_N; i++) begin
        regFile_q[i] <= cms_pkg::ZERO_WORD; // RULE_04
      end
    end else if (clkEn) begin
      if (busWr && isGpr && busIdx != cms_pkg::SP_IDX) begin
        regFile_q[busIdx] <= (busIdx == cms_pkg::PC_IDX) ? (busWd & cms_pkg::PC_ALIGN_MASK)
                                                         : busWd; // RULE_09
      end
      if (coreGprWr && coreEvt.gprIdx != cms_pkg::SP_IDX) begin
        regFile_q[coreEvt.gprIdx] <= (coreEvt.gprIdx == cms_pkg::PC_IDX) ?
                                     (coreEvt.gprData & cms_pkg::PC_ALIGN_MASK)
                                     : coreEvt.gprData; // RULE_09
      end
      if (coreEvt.callValid) begin
        regFile_q[cms_pkg::LR_IDX] <= coreEvt.retAddr; // RULE_08
      end
    end
  end

  // ----------------------------------------------------------------------
  // Banked stack pointer
  // ----------------------------------------------------------------------
  wire spBusCur = busWr && isGpr && busIdx == cms_pkg::SP_IDX;
  wire spCoreCur = coreGprWr && coreEvt.gprIdx == cms_pkg::SP_IDX;
  wire [cms_pkg::DATA_W-1:0] spCurData = spCoreCur ? coreEvt.gprData : busWd;
  wire mainSpWe = (busWr && isMsp) || ((spBusCur || spCoreCur) && !useProc); // RULE_06
  wire procSpWe = (busWr && isPsp) || ((spBusCur || spCoreCur) && useProc); // RULE_06
  wire [cms_pkg::DATA_W-1:0] mainSpData = (spBusCur || spCoreCur) ? spCurData : busWd;
  wire [cms_pkg::DATA_W-1:0] procSpData = (spBusCur || spCoreCur) ? spCurData : busWd;

  always_ff @(posedge clk) begin
    if (rstInt) begin
      mainSp_q <= cms_pkg::ZERO_WORD;
      procSp_q <= cms_pkg::ZERO_WORD;
    end else if (clkEn) begin
      if (mainSpWe) begin
        mainSp_q <= spAlign(mainSpData); // RULE_07
      end
      if (procSpWe) begin
        procSp_q <= spAlign(procSpData); // RULE_07
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode machine and status views
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      modeState_q <= cms_pkg::CMS_THREAD; // RULE_20
      excNum_q <= cms_pkg::EXCNUM_NONE;
    end else if (clkEn) begin
      case (modeState_q)
        cms_pkg::CMS_THREAD: begin
          if (coreEvt.excEnter) begin
            modeState_q <= cms_pkg::CMS_HANDLER; // RULE_03
            excNum_q <= coreEvt.excNum; // RULE_11
          end
        end
        cms_pkg::CMS_HANDLER: begin
          if (coreEvt.excEnter) begin
            excNum_q <= coreEvt.excNum; // RULE_11
          end else if (coreEvt.excReturn) begin
            modeState_q <= cms_pkg::CMS_THREAD; // RULE_03
            excNum_q <= cms_pkg::EXCNUM_NONE;
          end
        end
        default: begin
          modeState_q <= cms_pkg::CMS_THREAD;
        end
      endcase
    end
  end

  wire xpsrWe = busWr && isXpsr && !execClear; // RULE_13

  always_ff @(posedge clk) begin
    if (rstInt) begin
      appFlags_q <= '0;
      iciState_q <= '0;
      itState_q <= '0;
    end else if (clkEn) begin
      if (xpsrWe) begin
        appFlags_q <= busWd[cms_pkg::FLAGS_LSB +: cms_pkg::FLAGS_W]; // RULE_10
        iciState_q <= busWd[cms_pkg::ICI_LSB +: cms_pkg::ICI_W]; // RULE_12
        itState_q <= busWd[cms_pkg::IT_LSB +: cms_pkg::IT_W]; // RULE_12
      end
      if (coreEvt.flagsValid) begin
        appFlags_q <= coreEvt.flags; // RULE_10
      end
    end
  end

  // ----------------------------------------------------------------------
  // Masks and mode control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      globalIrqBlock_q <= 1'b0; // RULE_20
      faultLevelBlock_q <= 1'b0;
      priorityThreshold_q <= cms_pkg::PRIORITY_THRESHOLD_OFF;
      modeStackSelect_q <= cms_pkg::CTRL_RESET;
    end else if (clkEn) begin
      if (busWr && isPri) begin
        globalIrqBlock_q <= busWd[0];
      end
      if (busWr && isFlt) begin
        faultLevelBlock_q <= busWd[0];
      end
      if (busWr && isThr) begin
        priorityThreshold_q <= busWd[cms_pkg::PRIO_W-1:0];
      end
      if (busWr && isCtrl) begin
        modeStackSelect_q <= busWd[cms_pkg::CTRL_W-1:0]; // RULE_17 RULE_18
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault pulse and interrupt gating
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      fault_q <= 1'b0;
      irqAccept_q <= 1'b0;
    end else if (clkEn) begin
      fault_q <= privFault || execClear || narrowFault; // RULE_02 RULE_05 RULE_13
      irqAccept_q <= irqReq.valid && maskAllows(irqReq, globalIrqBlock_q, faultLevelBlock_q,
                                                priorityThreshold_q); // RULE_14 RULE_15 RULE_16
    end
  end

  assign avs_readdata = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign faultEvent = fault_q;
  assign irqAccept = irqAccept_q;
  assign handlerMode = modeState_q[cms_pkg::MODE_HANDLER_BIT];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_exc_entry: assert property (@(posedge clk) disable iff (rstInt) // RULE_03
    (clkEn && coreEvt.excEnter) |=> (handlerMode && excNum_q == $past(coreEvt.excNum)))
    else $error("Exception entry did not reach handler mode.");

  a_sp_aligned: assert property (@(posedge clk) disable iff (rstInt) // RULE_07
    (clkEn && mainSpWe) |=> (mainSp_q[1:0] == 2'h0 && mainSp_q[31:2] == $past(mainSpData[31:2])))
    else $error("Main stack pointer write not aligned.");

  a_pc_aligned: assert property (@(posedge clk) disable iff (rstInt) // RULE_09
    regFile_q[cms_pkg::PC_IDX][0] == 1'b0)
    else $error("Instruction pointer bit zero set.");

  a_call_link: assert property (@(posedge clk) disable iff (rstInt) // RULE_08
    (clkEn && coreEvt.callValid) |=> regFile_q[cms_pkg::LR_IDX] == $past(coreEvt.retAddr))
    else $error("Call did not load return link.");

  a_unpriv_block: assert property (@(posedge clk) disable iff (rstInt) // RULE_02
    (clkEn && busTake && avs_write && isCtrl && !privileged)
      |=> (faultEvent && $stable(modeStackSelect_q)))
    else $error("Unprivileged mode write was not blocked.");

  a_exec_bit_read: assert property (@(posedge clk) disable iff (rstInt) // RULE_13
    (clkEn && busReq && waitReq_q && isXpsr && privileged) |=> avs_readdata[cms_pkg::EXEC_BIT])
    else $error("Execution state bit read as zero.");

  a_nmi_pass: assert property (@(posedge clk) disable iff (rstInt) // RULE_15
    (clkEn && irqReq.valid && irqReq.kind == cms_pkg::CMS_EXC_NMI) |=> irqAccept)
    else $error("Non-maskable interrupt was blocked.");

  a_fault_blocks: assert property (@(posedge clk) disable iff (rstInt) // RULE_15
    (clkEn && faultLevelBlock_q && irqReq.kind != cms_pkg::CMS_EXC_NMI) |=> !irqAccept)
    else $error("Fault block let an exception through.");

  a_global_block: assert property (@(posedge clk) disable iff (rstInt) // RULE_14
    (clkEn && globalIrqBlock_q && irqReq.kind == cms_pkg::CMS_EXC_OTHER) |=> !irqAccept)
    else $error("Global block let an interrupt through.");

  a_thr_masks: assert property (@(posedge clk) disable iff (rstInt) // RULE_16
    (clkEn && irqReq.kind == cms_pkg::CMS_EXC_OTHER && priorityThreshold_q != cms_pkg::PRIORITY_THRESHOLD_OFF
     && irqReq.prio >= priorityThreshold_q) |=> !irqAccept)
    else $error("Threshold did not mask interrupt.");

  a_bus_answer: assert property (@(posedge clk) disable iff (rstInt)
    (clkEn && busReq && waitReq_q) |=> !avs_waitrequest ##1 (avs_waitrequest || !clkEn))
    else $error("Bus answer not one wait state.");

  a_handler_stack: assert property (@(posedge clk) disable iff (rstInt) // RULE_06
    handlerMode |-> !useProc && privileged)
    else $error("Handler mode on process stack or unprivileged.");

endmodule

// File: tb/tb_top.sv
// Self-checking bench for the core mode register file.
`timescale 1ns/10ps
module tb_top;
  logic clk, reset, clkEn, extRstN, rd, wr, waitReq, faultEvent, irqAccept, handlerMode;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, seed;
  logic [31:0] gv [13];
  cms_pkg::cms_core_evt_s ev;
  cms_pkg::cms_irq_req_s irq;
  int mismatches, samples_checked;
  logic [31:0] expQ [$];

  cms_cpu_mode_regs i_cms_cpu_mode_regs (.clk(clk), .reset(reset), .clkEn(clkEn),
    .external_reset_n_pin(extRstN), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitReq), .coreEvt(ev),
    .irqReq(irq), .faultEvent(faultEvent), .irqAccept(irqAccept), .handlerMode(handlerMode));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The request is held until waitrequest is sampled low, then released at that edge.
  task automatic busOp(input logic isWr, input logic [7:0] a, input logic [31:0] d,
      input logic f = 1'h0);
    int n;
    @(posedge clk);
    rd <= !isWr;
    wr <= isWr;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'h0 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    rd <= 1'h0;
    wr <= 1'h0;
    #1;
    chk(32'(faultEvent), 32'(f));
  endtask

  task automatic rdE(input logic [7:0] a, input logic [31:0] e, input logic f = 1'h0);
    expQ.push_back(e);
    busOp(1'h0, a, 32'h0, f);
  endtask

  task automatic coreEv(input cms_pkg::cms_core_evt_s e, input logic f);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    #1;
    chk(32'(faultEvent), 32'(f));
  endtask

  task automatic irqT(input logic p, input logic fm, input logic [8:0] thr,
      input cms_pkg::cms_exc_kind_e k, input logic [8:0] pr);
    logic ok;
    busOp(1'h1, cms_pkg::OFS_GLOBAL_IRQ_BLOCK, {31'h0, p});
    busOp(1'h1, cms_pkg::OFS_FAULT_LEVEL_BLOCK, {31'h0, fm});
    busOp(1'h1, cms_pkg::OFS_PRIORITY_THRESHOLD, {23'h0, thr});
    ok = (k == cms_pkg::CMS_EXC_NMI) || (!fm && (k == cms_pkg::CMS_EXC_HARD ||
        (!p && (thr == 9'h0 || pr < thr))));
    @(posedge clk);
    irq <= '{1'h1, k, pr};
    @(posedge clk);
    irq <= '0;
    #1;
    chk(32'(irqAccept), 32'(ok));
  endtask

  // ----------------------------------------------------------------------
  // Clock, monitor, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd === 1'h1 && waitReq === 1'h0) begin
      chk(rdata, expQ.pop_front());
    end
  end

  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  initial begin
    cms_pkg::cms_core_evt_s e;
    seed = 32'h67F5D050;
    mismatches = 0;
    samples_checked = 0;
    reset = 1'h1;
    clkEn = 1'h1;
    extRstN = 1'h1;
    rd = 1'h0;
    wr = 1'h0;
    addr = 8'h0;
    wdata = 32'h0;
    ev = '0;
    irq = '0;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    rdE(cms_pkg::OFS_COMBINED_PROGRAM_STATUS, 32'h0100_0000);
    rdE(cms_pkg::OFS_STATE, 32'h0000_0002);
    for (int a = 'h4C; a <= 'h58; a += 4) begin
      rdE(8'(a), 32'h0);
    end
    for (int i = 0; i < 13; i++) begin
      gv[i] = xs();
      busOp(1'h1, 8'(i * 4), gv[i]);
      rdE(8'(i * 4), gv[i]);
    end
    v = xs();
    busOp(1'h1, 8'h3C, v);
    rdE(8'h3C, v & cms_pkg::PC_ALIGN_MASK);
    busOp(1'h1, 8'h34, v);
    rdE(cms_pkg::OFS_MSP, v & cms_pkg::SP_ALIGN_MASK);
    busOp(1'h1, cms_pkg::OFS_CONTROL, 32'h2);
    busOp(1'h1, 8'h34, ~v);
    rdE(cms_pkg::OFS_PSP, ~v & cms_pkg::SP_ALIGN_MASK);
    rdE(cms_pkg::OFS_MSP, v & cms_pkg::SP_ALIGN_MASK);
    rdE(cms_pkg::OFS_STATE, 32'h0000_0006);
    e = '0;
    e.callValid = 1'h1;
    e.retAddr = xs();
    coreEv(e, 1'h0);
    rdE(8'h38, e.retAddr);
    clkEn <= 1'h0;
    v = e.retAddr;
    e.retAddr = xs();
    coreEv(e, 1'h0);
    clkEn <= 1'h1;
    rdE(8'h38, v);
    e = '0;
    e.flagsValid = 1'h1;
    e.flags = 5'h15;
    coreEv(e, 1'h0);
    rdE(cms_pkg::OFS_COMBINED_PROGRAM_STATUS, 32'hA900_0000);
    e = '0;
    e.excEnter = 1'h1;
    e.excNum = 9'h1A5;
    coreEv(e, 1'h0);
    chk(32'(handlerMode), 32'h1);
    rdE(cms_pkg::OFS_COMBINED_PROGRAM_STATUS, 32'hA900_01A5);
    rdE(cms_pkg::OFS_STATE, 32'h01A5_0003);
    busOp(1'h1, 8'h34, 32'h0000_1237);
    rdE(cms_pkg::OFS_MSP, 32'h0000_1234);
    e = '0;
    e.excReturn = 1'h1;
    coreEv(e, 1'h0);
    chk(32'(handlerMode), 32'h0);
    v = (xs() & 32'hFE00_FC00) | 32'h0100_0000;
    busOp(1'h1, cms_pkg::OFS_COMBINED_PROGRAM_STATUS, v);
    rdE(cms_pkg::OFS_COMBINED_PROGRAM_STATUS, v);
    busOp(1'h1, cms_pkg::OFS_COMBINED_PROGRAM_STATUS, v & 32'hFEFF_FFFF, 1'h1);
    rdE(cms_pkg::OFS_COMBINED_PROGRAM_STATUS, v);
    busOp(1'h1, cms_pkg::OFS_GLOBAL_IRQ_BLOCK, 32'h1);
    busOp(1'h1, cms_pkg::OFS_CONTROL, 32'h1);
    rdE(cms_pkg::OFS_GLOBAL_IRQ_BLOCK, 32'h0, 1'h1);
    busOp(1'h1, cms_pkg::OFS_CONTROL, 32'h0, 1'h1);
    rdE(cms_pkg::OFS_STATE, 32'h0000_0000);
    e = '0;
    e.excEnter = 1'h1;
    e.excNum = 9'h003;
    coreEv(e, 1'h0);
    rdE(cms_pkg::OFS_CONTROL, 32'h1);
    busOp(1'h1, cms_pkg::OFS_CONTROL, 32'h0);
    e = '0;
    e.excReturn = 1'h1;
    coreEv(e, 1'h0);
    rdE(cms_pkg::OFS_STATE, 32'h0000_0002);
    foreach (gv[i]) begin
      if (i >= 7 && i <= 12) begin
        e = '0;
        e.gprWrValid = 1'h1;
        e.gprNarrow = 1'h1;
        e.gprIdx = 4'(i);
        e.gprData = xs();
        coreEv(e, i > 7);
        rdE(8'(i * 4), (i > 7) ? gv[i] : e.gprData);
      end
    end
    rdE(8'h60, 32'h0);
    busOp(1'h1, 8'h60, 32'hFFFF_FFFF);
    for (int i = 0; i < 24; i++) begin
      v = xs();
      irqT(i % 4 == 1, i % 4 == 2, v[3] ? 9'h0 : v[12:4], cms_pkg::cms_exc_kind_e'(i % 3),
          v[5] ? v[12:4] : v[24:16]);
    end
    busOp(1'h1, cms_pkg::OFS_CONTROL, 32'h2);
    @(posedge clk);
    extRstN <= 1'h0;
    repeat (4) @(posedge clk);
    extRstN <= 1'h1;
    repeat (3) @(posedge clk);
    rdE(cms_pkg::OFS_CONTROL, 32'h0);
    rdE(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(expQ.size()), 32'h0);
    give_verdict();
  end
endmodule
